// >>> rtl/isf_pkg.sv
// Package: register map, field layout, reset values and states of the slave
package isf_pkg;
  localparam logic [7:0] FIFO_COUNTS_ADDR = 8'hf5;
  localparam logic [7:0] ADDR_MASK_ADDR   = 8'hff;
  localparam int         TX_CNT_LSB       = 4;
  localparam int         RX_CNT_LSB       = 0;
  localparam int         FORCE_BIT        = 7;
  localparam logic [6:0] MASK_RESET       = 7'h7f;
  localparam logic       FORCE_RESET      = 1'b1;
  localparam logic [6:0] OWN_ADDR_RESET   = 7'h00;
  localparam int         SYNC_STAGES      = 2;

  typedef enum logic [2:0] {
    ISF_IDLE,
    ISF_ADDR,
    ISF_ACK,
    ISF_HOLD,
    ISF_DATA,
    ISF_SKIP
  } isf_state_t;
endpackage : isf_pkg

// >>> rtl/isf_slave.sv
// I2C slave address match, forced stretch and fifo count registers
`timescale 1ns/100ps
// Notes on behaviour
// - Tx fifo count read at bits 6:4
// - Rx fifo count read at bits 2:0
// - Force bit set: flag after address ack
// - Force clear: address ack alone no flag
// - Mask one: compare address bit
// - Mask zero: address bit is don't-care
// - Reset: mask all ones, force one
module isf_slave
  import isf_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  // Register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // Own address and fifo levels from neighbouring logic
  input  wire logic [6:0] own_slave_address_i,
  input  wire logic [2:0] tx_fill_count_i,
  input  wire logic [2:0] rx_fill_count_i,
  // Flag handling and other flag sources
  input  wire logic       flag_clear_i,
  input  wire logic       flag_other_set_i,
  output logic            slave_event_flag_o,
  output logic            addr_match_o,
  output logic            read_dir_o,
  // I2C pins
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe_o,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o
);
  typedef struct packed {
    logic [6:0] addr_compare_mask;
    logic       force_addr_stretch;
    logic [7:0] rdata;
    isf_state_t state;
    logic [3:0] bits;
    logic [7:0] shift;
    logic       scl_q;
    logic       sda_q;
    logic       flag;
    logic       hold;
    logic       ack_drive;
    logic       match;
    logic       rw;
  } isf_slave_state_t;

  isf_slave_state_t st;
  isf_slave_state_t next_st;
  logic [1:0]       pins_sync;
  logic             scl_s;
  logic             sda_s;
  logic             scl_rise;
  logic             scl_fall;
  logic             start_seen;
  logic             stop_seen;
  logic             addr_hit;

  // Pins cross into this clock through two flops; a pulse shorter than
  // one clock can be lost, so the bus must run far slower than the clock
  isf_sync #(
    .WIDTH (2)
  ) isf_sync_inst (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .d_i      ({scl_i, sda_i}),
    .q_o      (pins_sync)
  );

  // History flops reset to one like the idle bus, so no false edge
  // and no false start follows reset
  assign scl_s      = pins_sync[1];
  assign sda_s      = pins_sync[0];
  assign scl_rise   = scl_s && !st.scl_q;
  assign scl_fall   = !scl_s && st.scl_q;
  assign start_seen = scl_s && st.scl_q && st.sda_q && !sda_s;
  assign stop_seen  = scl_s && st.scl_q && !st.sda_q && sda_s;
  // Masked compare; after eight bits the address sits in shift[7:1]
  assign addr_hit = ((st.shift[7:1] ^ own_slave_address_i)
                     & st.addr_compare_mask) == 7'h00;

  always_comb begin
    next_st       = st;
    next_st.scl_q = scl_s;
    next_st.sda_q = sda_s;

    // Register writes; the count register ignores writes entirely
    if (reg_wr_i && reg_addr_i == ADDR_MASK_ADDR) begin
      next_st.addr_compare_mask  = reg_wdata_i[6:0];
      next_st.force_addr_stretch = reg_wdata_i[FORCE_BIT];
    end

    // Read data is registered, so it follows the address one cycle late
    next_st.rdata = 8'h00;
    case (reg_addr_i)
      FIFO_COUNTS_ADDR: begin
        next_st.rdata[TX_CNT_LSB +: 3] = tx_fill_count_i;
        next_st.rdata[RX_CNT_LSB +: 3] = rx_fill_count_i;
      end
      ADDR_MASK_ADDR: begin
        next_st.rdata = {st.force_addr_stretch, st.addr_compare_mask};
      end
      default: begin
        next_st.rdata = 8'h00;
      end
    endcase

    // Flag: a set in the same cycle as a clear wins
    if (flag_clear_i) begin
      next_st.flag = 1'b0;
    end
    if (flag_other_set_i) begin
      next_st.flag = 1'b1;
    end

    case (st.state)
      ISF_IDLE: begin
        // Nothing to do until a start appears
        next_st.bits = 4'h0;
      end
      ISF_ADDR: begin
        if (scl_rise) begin
          next_st.shift = {st.shift[6:0], sda_s};
          next_st.bits  = st.bits + 4'h1;
        end
        if (scl_fall && st.bits == 4'h8) begin
          // Direction is kept even for a foreign address; the match
          // output tells firmware whether the byte was ours
          next_st.rw = st.shift[0];
          if (addr_hit) begin
            next_st.match     = 1'b1;
            next_st.ack_drive = 1'b1;
            next_st.state     = ISF_ACK;
          end else begin
            next_st.state = ISF_SKIP;
          end
        end
      end
      ISF_ACK: begin
        if (scl_fall) begin
          next_st.ack_drive = 1'b0;
          next_st.bits      = 4'h0;
          if (st.force_addr_stretch) begin
            // Hold SCL low from the ack's falling edge
            next_st.flag  = 1'b1;
            next_st.hold  = 1'b1;
            next_st.state = ISF_HOLD;
          end else begin
            next_st.state = ISF_DATA;
          end
        end
      end
      ISF_HOLD: begin
        // Let go only once firmware has cleared the flag; a set from
        // another source meeting the clear keeps the clock held
        if (!st.flag) begin
          next_st.hold  = 1'b0;
          next_st.state = ISF_DATA;
        end
      end
      ISF_DATA, ISF_SKIP: begin
        // Data bytes belong to neighbouring logic; a foreign address
        // waits here for the next start or stop
        next_st.bits = 4'h0;
      end
      default: begin
        next_st.state = ISF_IDLE;
      end
    endcase

    // Start restarts address capture; stop ends any transfer
    if (start_seen) begin
      next_st.state     = ISF_ADDR;
      next_st.bits      = 4'h0;
      next_st.match     = 1'b0;
      next_st.hold      = 1'b0;
      next_st.ack_drive = 1'b0;
    end else if (stop_seen) begin
      // A stop in a stretch frees the clock; the flag waits for firmware
      next_st.state     = ISF_IDLE;
      next_st.match     = 1'b0;
      next_st.hold      = 1'b0;
      next_st.ack_drive = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st                    <= '0;
      st.addr_compare_mask  <= MASK_RESET;
      st.force_addr_stretch <= FORCE_RESET;
      st.state              <= ISF_IDLE;
      st.scl_q              <= 1'b1;
      st.sda_q              <= 1'b1;
      // Open-drain enables must come up released
      st.hold               <= 1'b0;
      st.ack_drive          <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from flops, so the pins never glitch
  // Open-drain: only ever pull low
  assign reg_rdata_o        = st.rdata;
  assign slave_event_flag_o = st.flag;
  assign addr_match_o       = st.match;
  assign read_dir_o         = st.rw;
  assign scl_o              = 1'b0;
  assign scl_oe_o           = st.hold;
  assign sda_o              = 1'b0;
  assign sda_oe_o           = st.ack_drive;
endmodule : isf_slave

// >>> rtl/isf_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module isf_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  // Data
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } isf_sync_state_t;

  isf_sync_state_t st;
  isf_sync_state_t next_st;

  always_comb begin
    next_st.meta = d_i;
    next_st.sync = st.meta;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st <= '{meta: {WIDTH{1'b1}}, sync: {WIDTH{1'b1}}};
    end else begin
      st <= next_st;
    end
  end

  assign q_o = st.sync;
endmodule : isf_sync

// >>> verif/isf_i2c_master.sv
// Bus master model sending address bytes with a 160 ns bit clock
`timescale 1ns/100ps
module isf_i2c_master (
  // Resolved bus lines
  input  wire logic scl_i,
  input  wire logic sda_i,
  // Pulls, high pulls the line low
  output logic      scl_lo_o,
  output logic      sda_lo_o
);
  initial begin
    scl_lo_o = 1'b0;
    sda_lo_o = 1'b0;
  end
  // Start, eight bits MSB first, ack clock; ends holding the clock low
  task automatic send(input logic [7:0] a, output logic ack);
    sda_lo_o = 1'b1;
    #40 scl_lo_o = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      #40 sda_lo_o = !a[i];
      #40 scl_lo_o = 1'b0;
      #80 scl_lo_o = 1'b1;
    end
    #40 sda_lo_o = 1'b0;
    #40 scl_lo_o = 1'b0;
    #40 ack = !sda_i;
    #40 scl_lo_o = 1'b1;
  endtask : send
  // Waits out a stretched clock, bounded, before the stop
  task automatic stop(output logic ok);
    #40 sda_lo_o = 1'b1;
    #40 scl_lo_o = 1'b0;
    for (int n = 0; n < 400 && !scl_i; n++) #4;
    ok = scl_i;
    #40 sda_lo_o = 1'b0;
  endtask : stop
endmodule : isf_i2c_master

// >>> verif/isf_properties.sv
// Concurrent checks on the slave's register and pin ports
`timescale 1ns/100ps
module isf_properties (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       resetn_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [2:0] tx_fill_count_i,
  input wire logic [2:0] rx_fill_count_i,
  // Flag and pins
  input wire logic       flag_clear_i,
  input wire logic       slave_event_flag_o,
  input wire logic       scl_o,
  input wire logic       scl_oe_o,
  input wire logic       sda_o,
  input wire logic       sda_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_cnt;
    reg_addr_i == 8'hf5;
  endsequence
  sequence s_wr_mask;
    reg_wr_i && reg_addr_i == 8'hff ##1 reg_addr_i == 8'hff;
  endsequence
  AST_TX_CNT: assert property (s_cnt |=>
    reg_rdata_o[6:4] == $past(tx_fill_count_i)) else $error("tx count");
  AST_RX_CNT: assert property (s_cnt |=>
    reg_rdata_o[2:0] == $past(rx_fill_count_i)) else $error("rx count");
  AST_RSVD: assert property (s_cnt |=>
    !reg_rdata_o[7] && !reg_rdata_o[3]) else $error("reserved bits");
  AST_UNMAPPED: assert property (reg_addr_i != 8'hf5 &&
    reg_addr_i != 8'hff |=> reg_rdata_o == 8'h00) else $error("unmapped");
  AST_MASK_RD: assert property (s_wr_mask |=>
    reg_rdata_o == $past(reg_wdata_i, 2)) else $error("mask readback");
  AST_HOLD: assert property (slave_event_flag_o && !flag_clear_i
    |=> slave_event_flag_o) else $error("flag dropped");
  AST_RELEASE: assert property ($fell(slave_event_flag_o)
    |=> !scl_oe_o) else $error("clock not released");
  AST_OPEN_DRAIN: assert property (!scl_o && !sda_o
    && !(scl_oe_o && sda_oe_o)) else $error("pin high or both held");
  AST_STRETCH_FLAG: assert property ($rose(scl_oe_o)
    |-> slave_event_flag_o) else $error("stretch without flag");
endmodule : isf_properties

// >>> verif/tb_isf_slave.sv
// Self-checking bench for the slave address match and count registers
`timescale 1ns/100ps
module tb_isf_slave;
  import isf_pkg::*;
  logic       clk_i = 1'b0, resetn_i = 1'b0, reg_wr_i = 1'b0, ack, stop_ok;
  logic       flag_clear_i = 1'b0, flag_other_set_i = 1'b0, m_scl, m_sda;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  logic [6:0] own_slave_address_i = 7'h2a;
  logic [2:0] tx_fill_count_i = 3'h5, rx_fill_count_i = 3'h6;
  logic       slave_event_flag_o, addr_match_o, read_dir_o;
  logic       scl_o, scl_oe_o, sda_o, sda_oe_o;
  int         fails = 0, compares = 0;
  // Pull-ups on both lines
  wire        scl = !(m_scl || scl_oe_o);
  wire        sda = !(m_sda || sda_oe_o);
  isf_slave isf_slave_inst (.*, .scl_i(scl), .sda_i(sda));
  isf_i2c_master isf_i2c_master_inst (.scl_i(scl), .sda_i(sda),
    .scl_lo_o(m_scl), .sda_lo_o(m_sda));
  always #2 clk_i = ~clk_i;
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rd(logic [7:0] a, logic [7:0] e, string n);
    reg_addr_i = a;
    @(negedge clk_i);
    chk(n, reg_rdata_o, e);
  endtask : rd
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask : wr
  // One addressed transfer, then clear the flag and stop
  task automatic t_addr(logic [7:0] cfg, logic [7:0] a, logic ea, logic ef);
    wr(ADDR_MASK_ADDR, cfg);
    rd(ADDR_MASK_ADDR, cfg, "mask");
    isf_i2c_master_inst.send(a, ack);
    repeat (30) @(negedge clk_i);
    chk("ack", 8'(ack), 8'(ea));
    chk("match", 8'(addr_match_o), 8'(ea));
    chk("direction", 8'(read_dir_o), 8'(a[0]));
    chk("flag", 8'(slave_event_flag_o), 8'(ef));
    chk("stretch", 8'(scl_oe_o), 8'(ef));
    flag_clear_i = 1'b1;
    @(negedge clk_i);
    flag_clear_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk("release", 8'(scl_oe_o), 8'h00);
    isf_i2c_master_inst.stop(stop_ok);
    chk("stop", 8'(stop_ok), 8'h01);
    // Realign to the falling edge and let the stop pass the synchroniser
    repeat (5) @(negedge clk_i);
    chk("idle", {6'h00, scl, sda}, 8'h03);
    chk("match end", 8'(addr_match_o), 8'h00);
  endtask : t_addr
  // Other sources set the flag; a set meeting a clear wins
  task automatic t_other();
    flag_other_set_i = 1'b1;
    flag_clear_i = 1'b1;
    @(negedge clk_i);
    flag_other_set_i = 1'b0;
    flag_clear_i = 1'b0;
    @(negedge clk_i);
    chk("other set", 8'(slave_event_flag_o), 8'h01);
    chk("no stretch", 8'(scl_oe_o), 8'h00);
    flag_clear_i = 1'b1;
    @(negedge clk_i);
    flag_clear_i = 1'b0;
    @(negedge clk_i);
    chk("cleared", 8'(slave_event_flag_o), 8'h00);
  endtask : t_other
  task automatic end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (4) @(negedge clk_i);
    resetn_i = 1'b1;
    rd(ADDR_MASK_ADDR, 8'hff, "reset mask");
    rd(FIFO_COUNTS_ADDR, 8'h56, "counts");
    rd(8'h3c, 8'h00, "unmapped");
    tx_fill_count_i = 3'h7;
    rx_fill_count_i = 3'h1;
    wr(FIFO_COUNTS_ADDR, 8'h00);
    rd(FIFO_COUNTS_ADDR, 8'h71, "counts full");
    rd(ADDR_MASK_ADDR, 8'hff, "mask kept");
    t_addr(8'hff, 8'h54, 1'b1, 1'b1);
    t_addr(8'hff, 8'h56, 1'b0, 1'b0);
    t_addr(8'h7e, 8'h57, 1'b1, 1'b0);
    t_addr(8'hbf, 8'hd4, 1'b1, 1'b1);
    t_other();
    // A reset in mid-run must bring back the mask and the force bit
    resetn_i = 1'b0;
    repeat (2) @(negedge clk_i);
    resetn_i = 1'b1;
    rd(ADDR_MASK_ADDR, 8'hff, "mask after reset");
    end_of_test();
  end
endmodule : tb_isf_slave
bind isf_slave isf_properties isf_properties_inst (.*);
